// ===== ldm_pkg.sv
package ldm_pkg;

    // ------------------------------------------------------------------
    // Register indices; byte address is four times the index
    // ------------------------------------------------------------------
    localparam logic [7:0] LDM_IDX_CONFIG = 8'h10;
    localparam logic [7:0] LDM_IDX_ENABLE = 8'h11;
    localparam logic [7:0] LDM_IDX_STATUS = 8'h12;
    localparam logic [7:0] LDM_IDX_ALT    = 8'h13;
    localparam logic [7:0] LDM_IDX_MODE   = 8'h1f;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int LDM_CFG_AMI     = 7;
    localparam int LDM_CFG_LOS_HI  = 6;
    localparam int LDM_CFG_LOS_LO  = 5;
    localparam int LDM_CFG_ALG     = 2;
    localparam int LDM_CFG_STRICT  = 1;
    localparam int LDM_ST_VIOL     = 7;
    localparam int LDM_ST_LOSCHG   = 6;
    localparam int LDM_ST_SIG      = 5;
    localparam int LDM_ST_ZRUN     = 4;
    localparam int LDM_ST_SIGNAL_LOSS_STATE     = 0;
    localparam int LDM_ALT_EN      = 7;
    localparam int LDM_ALT_FLAG    = 6;
    localparam int LDM_ALT_STATE   = 0;
    localparam int LDM_MODE_T1     = 0;
    localparam int LDM_MODE_HOLD   = 1;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] LDM_CONFIG_RST = 8'h00;
    localparam logic [3:0] LDM_ENABLE_RST = 4'h0;
    localparam logic [1:0] LDM_MODE_RST   = 2'h0;

    // ------------------------------------------------------------------
    // Loss thresholds in bit periods, zero-run lengths, density figures
    // ------------------------------------------------------------------
    localparam logic [7:0] LDM_THR_E1_HDB3 = 8'd10;
    localparam logic [7:0] LDM_THR_T1_OR_AMI = 8'd15;
    localparam logic [7:0] LDM_THR_SEL1    = 8'd31;
    localparam logic [7:0] LDM_THR_SEL2    = 8'd63;
    localparam logic [7:0] LDM_THR_SEL3    = 8'd175;
    localparam logic [7:0] LDM_ZRUN_E1     = 8'd4;
    localparam logic [7:0] LDM_ZRUN_T1     = 8'd8;
    localparam logic [7:0] LDM_E1_GOOD_RUN = 8'd255;
    localparam int         LDM_T1_MAX_N    = 23;

endpackage : ldm_pkg

// ===== ldm_density_check.sv
`timescale 1ns/1ps
`default_nettype none

module ldm_density_check
    import ldm_pkg::*;
#(
    parameter int MAX_N = LDM_T1_MAX_N
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // Bit stream
    input  wire logic clear,
    input  wire logic bit_valid,
    input  wire logic mark,
    // Result
    output logic      density_ok
);

    localparam int WIN = 8 * (MAX_N + 1);

    initial begin
        if (MAX_N < 1 || MAX_N > 30) begin
            $error("ldm_density_check: MAX_N out of range");
        end
    end

    typedef struct packed {
        logic [WIN-1:0]       hist;
        logic [MAX_N-1:0][7:0] ones;
        logic                 ok;
    } ldm_dens_s;

    ldm_dens_s st;
    ldm_dens_s next_st;

    // ------------------------------------------------------------------
    // Sliding ones count for every window of 8(N+1) bits
    // ------------------------------------------------------------------
    always_comb begin
        logic all_ok;
        all_ok  = 1'b1;
        next_st = st;
        if (clear) begin
            next_st = '0;
        end else if (bit_valid) begin
            next_st.hist = {st.hist[WIN-2:0], mark};
            for (int n = 1; n <= MAX_N; n++) begin
                next_st.ones[n-1] = st.ones[n-1] + {7'h00, mark}
                                    - {7'h00, st.hist[8*(n+1)-1]};
                if (next_st.ones[n-1] < 8'(n)) begin
                    all_ok = 1'b0;
                end
            end
            next_st.ok = all_ok;
        end
    end

    // State register
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign density_ok = st.ok;

endmodule : ldm_density_check

`default_nettype wire

// ===== ldm_line_decoder.sv
// Contract
// - Receive hold keeps decoder registers at reset.
// - E1 HDB3 violation: stray or same-polarity signatures.
// - Strict select: only same-polarity bipolar violations.
// - Strict select ignored in T1 mode.
// - Algorithm select bit steers recovery loop.
// - AMI select disables HDB3 and B8ZS decoding.
// - E1 HDB3 signature replaced by four zeros.
// - T1 B8ZS signature replaced by eight zeros.
// - Loss threshold from mode, AMI and field.
// - Loss set past threshold, cleared by pulse.
// - Enables gate four events; reset to zero.
// - Event flags latch, clear on status read.
// - Zero-run flag at four E1, eight T1.
// - Signature flag on valid HDB3/B8ZS signature.
// - Loss change flag on any loss change.
// - Violation flag when stream breaks line code.
// - Alternate loss logic runs only without hold.
// - Alternate change flag, read clear, interrupt.
// - Alternate loss asserts after threshold zeros.
// - T1 alternate release needs pulse density windows.
// - E1 alternate release after 255 clean bits.
`timescale 1ns/1ps
`default_nettype none

module ldm_line_decoder
    import ldm_pkg::*;
#(
    parameter int ADDR_W = 8,
    parameter int MAX_N  = LDM_T1_MAX_N
) (
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              rst_n,
    // APB slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    // Line receiver side
    input  wire logic              rx_bit_valid,
    input  wire logic              rx_pos,
    input  wire logic              rx_neg,
    // Decoded data and status
    output logic                   dec_data,
    output logic                   dec_valid,
    output logic                   recovery_algorithm_sel,
    output logic                   signal_loss_state,
    output logic                   strict_loss_state,
    output logic                   irq_out_n
);

    initial begin
        if (ADDR_W < 7 || ADDR_W > 32) begin
            $error("ldm_line_decoder: ADDR_W out of range");
        end
    end

    // ------------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------------
    // threshold select
    function automatic logic [7:0] ldm_threshold(input logic       t1,
                                                 input logic       ami,
                                                 input logic [1:0] sel);
        logic [7:0] thr;
        thr = LDM_THR_SEL3;
        if (sel == 2'h0) begin
            thr = (t1 || ami) ? LDM_THR_T1_OR_AMI : LDM_THR_E1_HDB3;
        end else if (sel == 2'h1) begin
            thr = LDM_THR_SEL1;
        end else if (sel == 2'h2) begin
            thr = LDM_THR_SEL2;
        end
        return thr;
    endfunction : ldm_threshold

    function automatic logic ldm_hit(input logic [ADDR_W-1:0] a,
                                     input logic [7:0]        idx);
        return a == ADDR_W'({idx, 2'b00});
    endfunction : ldm_hit

    typedef struct packed {
        logic [7:0]  cfg;
        logic [3:0]  en;
        logic [3:0]  flags;
        logic        los;
        logic        alt_en;
        logic        alt_flag;
        logic        alt_los;
        logic [1:0]  mode;
        logic [7:0]  zcnt;
        logic [7:0]  good;
        logic        seen;
        logic        last_pol;
        logic        bpv_seen;
        logic        last_bpv_pol;
        logic [7:0]  hmark;
        logic [7:0]  hpol;
        logic [7:0]  hprev;
        logic [7:0]  hbpv;
        logic [7:0]  dly;
        logic        dec_data;
        logic        dec_valid;
        logic [31:0] prdata;
        logic        pslverr;
    } ldm_state_s;

    ldm_state_s st;
    ldm_state_s next_st;
    logic       density_ok;

    // ------------------------------------------------------------------
    // T1 pulse density checker for alternate loss release
    // ------------------------------------------------------------------
    ldm_density_check #(
        .MAX_N      (MAX_N)
    ) u_density (
        .clk        (clk),
        .rst_n      (rst_n),
        .clear      (st.mode[LDM_MODE_HOLD] | ~st.alt_los),
        .bit_valid  (rx_bit_valid),
        .mark       (rx_pos | rx_neg),
        .density_ok (density_ok)
    );

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    always_comb begin
        logic       t1;
        logic       ami;
        logic       hold;
        logic       access;
        logic       setup;
        logic       mark;
        logic       pol;
        logic       bpv;
        logic       e1_sig;
        logic       t1_sig;
        logic       lcv;
        logic       zrun;
        logic       los_nx;
        logic       alt_nx;
        logic       rd_stat;
        logic       rd_alt;
        logic [7:0] thr;
        logic [7:0] zc;
        logic [7:0] nm;
        logic [7:0] np;
        logic [3:0] ev;
        t1      = st.mode[LDM_MODE_T1];
        hold    = st.mode[LDM_MODE_HOLD];
        ami     = st.cfg[LDM_CFG_AMI];
        access  = psel && penable;
        setup   = psel && !penable;
        mark    = rx_pos | rx_neg;
        pol     = rx_pos;
        bpv     = 1'b0;
        e1_sig  = 1'b0;
        t1_sig  = 1'b0;
        lcv     = 1'b0;
        zrun    = 1'b0;
        los_nx  = st.los;
        alt_nx  = st.alt_los;
        rd_stat = access && !pwrite && ldm_hit(paddr, LDM_IDX_STATUS);
        rd_alt  = access && !pwrite && ldm_hit(paddr, LDM_IDX_ALT);
        thr     = ldm_threshold(t1, ami, {st.cfg[LDM_CFG_LOS_HI], st.cfg[LDM_CFG_LOS_LO]});
        zc      = st.zcnt;
        nm      = {st.hmark[6:0], mark};
        np      = {st.hpol[6:0], pol};
        ev      = 4'h0;
        next_st = st;
        next_st.dec_valid = 1'b0;

        // Register writes at the access phase
        if (access && pwrite) begin
            if (ldm_hit(paddr, LDM_IDX_CONFIG)) begin
                next_st.cfg = pwdata[7:0];
            end else if (ldm_hit(paddr, LDM_IDX_ENABLE)) begin
                next_st.en = pwdata[7:4];
            end else if (ldm_hit(paddr, LDM_IDX_ALT)) begin
                next_st.alt_en = pwdata[LDM_ALT_EN];
            end else if (ldm_hit(paddr, LDM_IDX_MODE)) begin
                next_st.mode = pwdata[1:0];
            end
        end

        // Line symbol processing, one step per bit period
        if (rx_bit_valid) begin
            bpv = mark && st.seen && (pol == st.last_pol);
            // E1 signature: violation after two zeros
            e1_sig = !t1 && bpv && !st.hmark[0] && !st.hmark[1];
            t1_sig = t1 && (nm == 8'h1b) && (np[4] == st.hprev[6])
                     && (np[3] != np[4]) && (np[1] == np[3]) && (np[0] == np[4])
                     && (np[4] == st.hprev[6]);
            next_st.hmark = nm;
            next_st.hpol  = np;
            next_st.hprev = {st.hprev[6:0], st.last_pol};
            next_st.hbpv  = {st.hbpv[6:0], bpv};
            if (mark) begin
                next_st.seen     = 1'b1;
                next_st.last_pol = pol;
            end
            if (t1) begin
                if (ami) begin
                    lcv = bpv;
                end else begin
                    if (t1_sig) begin
                        next_st.hbpv[4] = 1'b0;
                        next_st.hbpv[1] = 1'b0;
                    end
                    lcv = st.hbpv[7];
                end
            end else if (ami) begin
                lcv = bpv;
            end else if (st.cfg[LDM_CFG_STRICT]) begin
                lcv = bpv && st.bpv_seen && (pol == st.last_bpv_pol);
            end else begin
                lcv = (bpv && !e1_sig)
                      || (e1_sig && st.bpv_seen && (pol == st.last_bpv_pol));
            end
            if (bpv) begin
                next_st.bpv_seen     = 1'b1;
                next_st.last_bpv_pol = pol;
            end
            // Decoded bit delay line with substitution
            next_st.dly       = {st.dly[6:0], mark};
            next_st.dec_data  = st.dly[7];
            next_st.dec_valid = 1'b1;
            if (!ami && e1_sig) begin
                next_st.dly[3:0] = 4'h0;
            end else if (!ami && t1_sig) begin
                next_st.dly = 8'h00;
            end
            // Zero run counting
            zc   = mark ? 8'h00 : ((st.zcnt == 8'hff) ? st.zcnt : st.zcnt + 8'h01);
            next_st.zcnt = zc;
            zrun = !mark && (zc == (t1 ? LDM_ZRUN_T1 : LDM_ZRUN_E1));
            // set past threshold, clear on pulse
            if (mark) begin
                los_nx = 1'b0;
            end else if (zc > thr) begin
                los_nx = 1'b1;
            end
            if (zc >= LDM_ZRUN_E1) begin
                next_st.good = 8'h00;
            end else if (st.good != LDM_E1_GOOD_RUN) begin
                next_st.good = st.good + 8'h01;
            end
            if (!st.alt_los && zc >= thr) begin
                alt_nx = 1'b1;
            end else if (st.alt_los && !t1 && next_st.good == LDM_E1_GOOD_RUN) begin
                alt_nx = 1'b0;
            end
        end
        if (st.alt_los && t1 && density_ok) begin
            alt_nx = 1'b0;
        end

        // violation, loss change, signature, zero run
        ev = {lcv, los_nx != st.los, e1_sig | t1_sig, zrun};
        next_st.los = los_nx;
        // read clears only what was read, set wins
        next_st.flags = (rd_stat ? (st.flags & ~st.prdata[7:4]) : st.flags) | ev;

        // alternate loss runs only without hold
        next_st.alt_los = alt_nx;
        // change flag, read clears, set wins
        next_st.alt_flag = (rd_alt ? (st.alt_flag & ~st.prdata[LDM_ALT_FLAG]) : st.alt_flag)
                           | (alt_nx != st.alt_los);

        // Read data captured in the setup cycle
        if (setup) begin
            next_st.prdata  = 32'h0000_0000;
            next_st.pslverr = 1'b0;
            if (ldm_hit(paddr, LDM_IDX_CONFIG)) begin
                next_st.prdata[7:0] = st.cfg;
            end else if (ldm_hit(paddr, LDM_IDX_ENABLE)) begin
                next_st.prdata[7:4] = st.en;
            end else if (ldm_hit(paddr, LDM_IDX_STATUS)) begin
                next_st.prdata[7:4]         = st.flags;
                next_st.prdata[LDM_ST_SIGNAL_LOSS_STATE] = st.los;
            end else if (ldm_hit(paddr, LDM_IDX_ALT)) begin
                next_st.prdata[LDM_ALT_EN]    = st.alt_en;
                next_st.prdata[LDM_ALT_FLAG]  = st.alt_flag;
                next_st.prdata[LDM_ALT_STATE] = st.alt_los;
            end else if (ldm_hit(paddr, LDM_IDX_MODE)) begin
                next_st.prdata[1:0] = st.mode;
            end else begin
                next_st.pslverr = 1'b1;
            end
        end

        // hold keeps registers and decoder at reset
        if (hold) begin
            next_st.cfg          = LDM_CONFIG_RST;
            next_st.en           = LDM_ENABLE_RST;
            next_st.flags        = 4'h0;
            next_st.los          = 1'b0;
            next_st.alt_en       = 1'b0;
            next_st.alt_flag     = 1'b0;
            next_st.alt_los      = 1'b0;
            next_st.zcnt         = 8'h00;
            next_st.good         = 8'h00;
            next_st.seen         = 1'b0;
            next_st.bpv_seen     = 1'b0;
            next_st.hmark        = 8'h00;
            next_st.hbpv         = 8'h00;
            next_st.dly          = 8'h00;
            next_st.dec_data     = 1'b0;
            next_st.dec_valid    = 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st      <= '0;
            st.mode <= LDM_MODE_RST;
        end else begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign prdata                 = st.prdata;
    assign pready                 = 1'b1;
    assign pslverr                = st.pslverr & psel & penable;
    assign dec_data               = st.dec_data;
    assign dec_valid              = st.dec_valid;
    // algorithm select drives the recovery loop
    assign recovery_algorithm_sel = st.cfg[LDM_CFG_ALG];
    assign signal_loss_state      = st.los;
    assign strict_loss_state      = st.alt_los;
    assign irq_out_n = ~(|(st.flags & st.en) | (st.alt_flag & st.alt_en));

endmodule : ldm_line_decoder

`default_nettype wire

// ===== ldm_line_decoder_chk.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------
// Port checker
// ----------------
module ldm_line_decoder_chk #(
    parameter int ADDR_W = 8
) (
    // Clock and reset
    input wire logic              clk,
    input wire logic              rst_n,
    // APB
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0]       pwdata,
    input wire logic [31:0]       prdata,
    input wire logic              pready,
    input wire logic              pslverr,
    // Line side and status
    input wire logic              rx_bit_valid,
    input wire logic              rx_pos,
    input wire logic              rx_neg,
    input wire logic              dec_data,
    input wire logic              dec_valid,
    input wire logic              recovery_algorithm_sel,
    input wire logic              signal_loss_state,
    input wire logic              strict_loss_state,
    input wire logic              irq_out_n
);
    logic acc;
    logic mark;
    logic space;
    // Access phase and symbol kinds
    assign acc   = psel && penable;
    assign mark  = rx_bit_valid && (rx_pos || rx_neg);
    assign space = rx_bit_valid && !rx_pos && !rx_neg;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    dec_pulse_a: assert property (dec_valid == $past(rx_bit_valid))
        else $error("dec_valid not one clock after a bit");
    loss_clear_a: assert property (mark |=> !signal_loss_state)
        else $error("loss alarm kept after a pulse");
    loss_set_a: assert property ($rose(signal_loss_state) |-> $past(space) || $past(space, 2))
        else $error("loss alarm rose without a zero");
    loss_fall_a: assert property ($fell(signal_loss_state) |-> $past(mark) || $past(mark, 2)
        || $past(acc, 2)) else $error("loss alarm fell without a pulse");
    alt_lead_a: assert property ($rose(signal_loss_state) |-> strict_loss_state)
        else $error("alternate alarm not ahead of loss alarm");
    alt_set_a: assert property ($rose(strict_loss_state) |-> $past(space) || $past(space, 2))
        else $error("alternate alarm rose without a zero");
    alt_fall_a: assert property ($fell(strict_loss_state) |-> $past(rx_bit_valid)
        || $past(rx_bit_valid, 2) || $past(acc, 2)) else $error("alternate alarm fell idle");
    alg_sel_a: assert property (acc && pwrite && paddr == 8'h40
        |=> recovery_algorithm_sel == $past(pwdata[2])) else $error("algorithm select");
    irq_fall_a: assert property ($fell(irq_out_n) |-> $past(rx_bit_valid)
        || $past(rx_bit_valid, 2) || $past(acc)) else $error("interrupt without cause");
    irq_rise_a: assert property ($rose(irq_out_n) |-> $past(acc) || $past(acc, 2))
        else $error("interrupt released without access");
    // Main scenarios
    loss_c: cover property ($rose(signal_loss_state));
    alt_c: cover property ($fell(strict_loss_state));
    irq_c: cover property ($fell(irq_out_n));
endmodule : ldm_line_decoder_chk

bind ldm_line_decoder ldm_line_decoder_chk #(.ADDR_W(ADDR_W)) chk_u (
    .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rx_bit_valid(rx_bit_valid), .rx_pos(rx_pos), .rx_neg(rx_neg), .dec_data(dec_data),
    .dec_valid(dec_valid), .recovery_algorithm_sel(recovery_algorithm_sel),
    .signal_loss_state(signal_loss_state), .strict_loss_state(strict_loss_state),
    .irq_out_n(irq_out_n));
`default_nettype wire

// ===== ldm_line_rx_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------
// Line receiver model
// ----------------
module ldm_line_rx_model (
    // Clock
    input  wire logic clk,
    // Recovered symbols
    output var logic  rx_bit_valid,
    output var logic  rx_pos,
    output var logic  rx_neg
);
    logic last_pos;
    // Idle lines at time zero
    initial begin
        rx_bit_valid = 1'b0;
        rx_pos       = 1'b0;
        rx_neg       = 1'b0;
        last_pos     = 1'b0;
    end
    // Symbol: 0 space, 1 alternating mark, 2 mark of last polarity
    task automatic tx(input logic [1:0] s);
        logic p;
        p = (s == 2'h2) ? last_pos : !last_pos;
        @(posedge clk);
        rx_bit_valid <= 1'b1;
        rx_pos       <= (s != 2'h0) && p;
        rx_neg       <= (s != 2'h0) && !p;
        if (s != 2'h0) begin
            last_pos = p;
        end
        @(posedge clk);
        // Between bits the mark lines carry junk
        rx_bit_valid <= 1'b0;
        rx_pos       <= !rx_pos;
        rx_neg       <= !rx_neg;
    endtask : tx
endmodule : ldm_line_rx_model
`default_nettype wire

// ===== ldm_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) begin n_checks++; if ((got) !== (exp)) begin \
    failures++; \
    $display("[ERR] %s exp %h got %h", nm, exp, got); \
end end
// ----------------
// Bench top
// ----------------
module tb
    import ldm_pkg::*;
;
    typedef struct packed {logic t1; logic ami; logic [1:0] sel; logic [7:0] thr;} ldm_row_s;
    localparam logic [7:0] A_CFG = LDM_IDX_CONFIG << 2;
    localparam logic [7:0] A_EN  = LDM_IDX_ENABLE << 2;
    localparam logic [7:0] A_ST  = LDM_IDX_STATUS << 2;
    localparam logic [7:0] A_ALT = LDM_IDX_ALT << 2;
    localparam logic [7:0] A_MOD = LDM_IDX_MODE << 2;
    // Mode, AMI, threshold field, threshold
    ldm_row_s   rows [6] = '{'{0, 0, 0, 10}, '{1, 0, 0, 15}, '{0, 1, 0, 15},
                             '{0, 0, 1, 31}, '{1, 0, 2, 63}, '{0, 1, 3, 175}};
    logic [7:0] adrs [5] = '{A_CFG, A_EN, A_ST, A_ALT, A_MOD};
    logic        clk, rst_n, psel, penable, pwrite, pready, pslverr, rde;
    logic        rx_bit_valid, rx_pos, rx_neg, dec_data, dec_valid, alg_sel, loss, alt, irq_n;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rdq;
    int          failures = 0;
    int          n_checks = 0;
    ldm_line_decoder #(.ADDR_W(8), .MAX_N(LDM_T1_MAX_N)) dut_u (
        .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .rx_bit_valid(rx_bit_valid), .rx_pos(rx_pos), .rx_neg(rx_neg), .dec_data(dec_data),
        .dec_valid(dec_valid), .recovery_algorithm_sel(alg_sel), .signal_loss_state(loss),
        .strict_loss_state(alt), .irq_out_n(irq_n));
    ldm_line_rx_model lp_u (.clk(clk), .rx_bit_valid(rx_bit_valid), .rx_pos(rx_pos),
        .rx_neg(rx_neg));
    // Clock
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // APB transfer, result in rdq and rde
    task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= {24'h0, d};
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rdq = prdata;
        rde = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic play(input logic [1:0] q [$]);
        foreach (q[i]) lp_u.tx(q[i]);
    endtask : play
    task automatic send(input logic [1:0] s, input int n);
        repeat (n) lp_u.tx(s);
        repeat (2) @(posedge clk);
    endtask : send
    task automatic wrap_up();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : wrap_up
    // Watchdog
    initial begin
        repeat (60000) @(posedge clk);
        failures++;
        wrap_up();
    end
    // Main sequence
    initial begin
        {rst_n, psel, penable, pwrite, paddr, pwdata} = '0;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        foreach (rows[i]) begin
            apb(1, A_MOD, {7'h0, rows[i].t1});
            apb(1, A_CFG, {rows[i].ami, rows[i].sel, 5'h0});
            lp_u.tx(2'h1);
            send(0, rows[i].thr - 1);
            `CHK("alt early", 1'b0, alt)
            send(0, 1);
            `CHK("alt set", 1'b1, alt)
            `CHK("loss early", 1'b0, loss)
            send(0, 1);
            `CHK("loss set", 1'b1, loss)
            `CHK("irq masked", 1'b1, irq_n)
            apb(0, A_ST, 0);
            `CHK("status", 4'hb, {rdq[6:4], rdq[0]})
            send(1, 1);
            `CHK("loss clear", 1'b0, loss)
            send(1, 300);
            `CHK("alt clear", 1'b0, alt)
            apb(0, A_ALT, 0);
            `CHK("alt flag", 8'h40, rdq[7:0])
            apb(0, A_ST, 0);
            `CHK("loss change", 1'b1, rdq[6])
            apb(0, A_ST, 0);
            `CHK("read clear", 4'h0, rdq[7:4])
        end
        apb(1, A_CFG, 8'he6);
        apb(0, A_CFG, 0);
        `CHK("config", 8'he6, rdq[7:0])
        `CHK("alg sel", 1'b1, alg_sel)
        apb(1, A_EN, 8'hf0);
        apb(0, A_EN, 0);
        `CHK("enable", 8'hf0, rdq[7:0])
        apb(1, 8'h00, 8'h5a);
        `CHK("unmapped err", 1'b1, rde)
        apb(1, A_ALT, 8'h80);
        send(0, 4);
        `CHK("irq zero run", 1'b0, irq_n)
        apb(1, A_MOD, 8'h02);
        for (int i = 0; i < 4; i++) begin
            apb(0, adrs[i], 0);
            `CHK("hold value", 8'h00, rdq[7:0])
        end
        `CHK("irq hold", 1'b1, irq_n)
        apb(1, A_MOD, 0);
        apb(1, A_EN, 8'h10);
        play('{1, 0, 0});
        send(0, 1);
        `CHK("irq 3 zeros", 1'b1, irq_n)
        send(0, 9);
        `CHK("irq 4 zeros", 1'b0, irq_n)
        apb(0, A_ST, 0);
        @(posedge clk);
        `CHK("zero flag", 1'b1, rdq[4])
        `CHK("irq release", 1'b1, irq_n)
        play('{1, 0, 2});
        apb(0, A_ST, 0);
        `CHK("lone bpv", 2'b10, {rdq[7], rdq[5]})
        play('{1, 0, 0, 2});
        apb(0, A_ST, 0);
        `CHK("signature", 2'b01, {rdq[7], rdq[5]})
        apb(1, A_CFG, 8'h02);
        play('{1, 2});
        apb(0, A_ST, 0);
        `CHK("strict alt", 1'b0, rdq[7])
        play('{1, 1, 2});
        apb(0, A_ST, 0);
        `CHK("strict same", 1'b1, rdq[7])
        apb(1, A_MOD, 8'h01);
        play('{1, 2, 1, 1, 1, 1, 1, 1, 1, 1});
        apb(0, A_ST, 0);
        `CHK("t1 bpv", 1'b1, rdq[7])
        play('{1, 0, 0, 0, 2, 1, 0, 2, 1, 1, 1, 1, 1, 1, 1, 1, 1});
        apb(0, A_ST, 0);
        `CHK("b8zs", 2'b01, {rdq[7], rdq[5]})
        `CHK("b8zs data", 1'b0, dec_data)
        apb(1, A_EN, 8'hf0);
        rst_n <= 1'b0;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        foreach (adrs[i]) begin
            apb(0, adrs[i], 0);
            `CHK("reset value", 8'h00, rdq[7:0])
        end
        `CHK("irq reset", 1'b1, irq_n)
        wrap_up();
    end
endmodule : tb
`default_nettype wire
